// ---- rtl/sbd_ctrl.sv ----
// serial frame handling, bridge drive and diagnosis flags of the stepper driver
module sbd_ctrl import sbd_pkg::*; #(
	parameter int WAKE_CYC = WAKE_CYC_DEF
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic reset_i,
	// serial link pins
	input wire logic cs_low_i,
	input wire logic sclk_i,
	input wire logic sdi_i,
	output logic sdo_o,
	output logic sdo_oe_o,
	// enable pin and readiness
	input wire logic enable_low_input_i,
	output logic ready_o,
	// analog comparator and oscillator events, index 0 is bridge A
	input wire logic [1:0] osc_trig_i,
	input wire logic [1:0] oc_short_i,
	input wire logic [1:0] oc_nom_i,
	input wire logic [1:0] src_ovl_i,
	input wire logic [1:0] flyback_i,
	input wire logic overtemp_i,
	// bridge drives and status
	output sbd_gate_t gate_a_o,
	output sbd_gate_t gate_b_o,
	output logic diag_flag_upper_o,
	output logic diag_flag_lower_o
);
	sbd_pins_t pins_raw; // gathered raw pins
	sbd_pins_t lv; // filtered levels
	sbd_pins_t rs; // rising pulses
	sbd_pins_t fl; // falling pulses
	logic awake; // enable pin is low
	logic apply; // frame accepted this cycle
	logic cs_end; // select released this cycle
	logic flag_up; // status bits, active low as on the wire
	logic flag_lo;

	assign pins_raw = '{cs_low: cs_low_i, sclk: sclk_i, sdi: sdi_i,
		enable_low_input: enable_low_input_i, overtemp: overtemp_i, osc_trig: osc_trig_i,
		oc_short: oc_short_i, oc_nom: oc_nom_i, src_ovl: src_ovl_i, flyback: flyback_i};

	// every outside signal passes the same filter so relative order is kept
	sbd_sync #(.W(PINS_W), .INIT(PINS_IDLE)) u_sync (
		.clock_i(clock_i),
		.reset_i(reset_i),
		.async_i(pins_raw),
		.level_o(lv),
		.rise_o(rs),
		.fall_o(fl)
	);

	assign awake = ~lv.enable_low_input;

	// serial group
	logic in_frame_r, in_frame_nxt; // frame open
	logic [2:0] cnt_r, cnt_nxt; // clocks modulo eight
	logic any_r, any_nxt; // at least one clock seen
	logic [FRAME_BITS-1:0] rx_r, rx_nxt; // last eight bits received
	logic [FRAME_BITS-1:0] tx_r, tx_nxt; // outgoing byte
	logic [CFG_W-1:0] cfg_r, cfg_nxt; // applied bridge settings
	logic ready_r, ready_nxt; // wake delay elapsed
	logic [WAKE_W-1:0] wake_r, wake_nxt; // wake delay counter

	// frame capture, shifting and acceptance
	always_comb begin
		in_frame_nxt = in_frame_r;
		cnt_nxt = cnt_r;
		any_nxt = any_r;
		rx_nxt = rx_r;
		tx_nxt = tx_r;
		cfg_nxt = cfg_r;
		ready_nxt = ready_r;
		wake_nxt = wake_r;
		apply = 1'b0;
		cs_end = 1'b0;
		if (!awake) begin
			// disabled: everything except the receive register rx_r returns to its reset view
			in_frame_nxt = 1'b0;
			cnt_nxt = BIT_CNT_ZERO;
			any_nxt = 1'b0;
			tx_nxt = '1;
			cfg_nxt = CFG_RESET;
			ready_nxt = 1'b0;
			wake_nxt = '0;
		end else if (!ready_r) begin
			// frames that start early are ignored, the host owes the delay
			if (wake_r >= WAKE_W'(WAKE_CYC - 1)) begin
				ready_nxt = 1'b1; // RQ17
			end else begin
				wake_nxt = wake_r + WAKE_W'(1); // RQ17
			end
		end else begin
			if (fl.cs_low) begin
				// open a frame and present the status in the top bits
				in_frame_nxt = 1'b1; // RQ18
				cnt_nxt = BIT_CNT_ZERO;
				any_nxt = 1'b0;
				tx_nxt = {flag_up, flag_lo, cfg_r}; // RQ25
			end else if (in_frame_r && rs.cs_low) begin
				// close the frame; a partial byte leaves the bridge settings alone
				in_frame_nxt = 1'b0;
				cs_end = 1'b1; // RQ7
				if (any_r && cnt_r == BIT_CNT_ZERO) begin
					cfg_nxt = rx_r[CFG_W-1:0]; // RQ20 RQ26
					apply = 1'b1; // RQ20
				end
			end else if (in_frame_r && rs.sclk) begin
				// sample on the rising clock, older bits fall off the top
				rx_nxt = {rx_r[FRAME_BITS-2:0], lv.sdi}; // RQ18 RQ26
				cnt_nxt = cnt_r + 3'h1;
				any_nxt = 1'b1;
			end else if (in_frame_r && fl.sclk) begin
				tx_nxt = {tx_r[FRAME_BITS-2:0], 1'b1}; // RQ19
			end
		end
	end

	// register the serial group
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			in_frame_r <= 1'b0;
			cnt_r <= BIT_CNT_ZERO;
			any_r <= 1'b0;
			rx_r <= '0;
			tx_r <= '1;
			cfg_r <= CFG_RESET;
			ready_r <= 1'b0;
			wake_r <= '0;
		end else begin
			in_frame_r <= in_frame_nxt;
			cnt_r <= cnt_nxt;
			any_r <= any_nxt;
			rx_r <= rx_nxt;
			tx_r <= tx_nxt;
			cfg_r <= cfg_nxt;
			ready_r <= ready_nxt;
			wake_r <= wake_nxt;
		end
	end

	assign sdo_o = tx_r[FRAME_BITS-1];
	assign sdo_oe_o = ~lv.cs_low; // RQ21
	assign ready_o = ready_r;

	// bridge and diagnosis group
	sbd_sink_t sink_r [2];
	sbd_sink_t sink_nxt [2];
	logic [TMR_W-1:0] tmr_r [2]; // time since sink turn-on
	logic [TMR_W-1:0] tmr_nxt [2];
	logic [TMR_W-1:0] fly_tmr_r [2]; // flyback wait time
	logic [TMR_W-1:0] fly_tmr_nxt [2];
	logic [1:0] fly_wait_r, fly_wait_nxt; // waiting for a flyback pulse
	logic [1:0] pol_r, pol_nxt; // last seen polarity
	logic [1:0] ovl_off_r, ovl_off_nxt; // bridge shut by source overload
	logic [1:0] lock_r, lock_nxt; // sink held off after repeated shorts
	logic [3:0] vs_cnt_r [2]; // consecutive supply-short detections
	logic [3:0] vs_cnt_nxt [2];
	logic vs_short_r, vs_short_nxt; // shared supply-short flag
	logic ovl_r, ovl_nxt; // shared overload flag
	logic open_r, open_nxt; // shared open-load flag
	logic [2:0] filt_r, filt_nxt; // diagnosis filter events
	sbd_gate_t gate_r [2];
	sbd_gate_t gate_nxt [2];

	// sink sequencing, protection and flags
	always_comb begin
		sbd_bridge_cfg_t bc;
		logic active, hold, chop, vs_det, ovl_det, pol_chg, settled, vs_clr, vs_set;
		bc = '0;
		active = 1'b0;
		hold = 1'b0;
		chop = 1'b0;
		vs_det = 1'b0;
		ovl_det = 1'b0;
		pol_chg = 1'b0;
		vs_clr = 1'b0;
		vs_set = 1'b0;
		settled = (filt_r >= FILT_SETTLE);
		filt_nxt = filt_r;
		open_nxt = open_r;
		vs_short_nxt = vs_short_r;
		ovl_nxt = ovl_r;
		// any frame end, partial or whole, releases overload shut-off; a set in the same cycle wins below
		ovl_off_nxt = cs_end ? 2'b00 : ovl_off_r; // RQ7
		if (cs_end) begin
			ovl_nxt = 1'b0; // RQ7
		end
		lock_nxt = apply ? 2'b00 : lock_r; // RQ24
		pol_nxt = pol_r;
		fly_wait_nxt = fly_wait_r;
		for (int b = 0; b < 2; b++) begin
			bc = sbd_cfg_of(cfg_r, b);
			hold = (bc.current == HOLD_CURRENT_CODE);
			active = ready_r && (bc.current != CODE_OFF) && !ovl_off_r[b]; // RQ23
			chop = 1'b0;
			vs_det = 1'b0;
			ovl_det = active && rs.src_ovl[b];
			pol_chg = (bc.polarity != pol_r[b]);
			pol_nxt[b] = bc.polarity;
			sink_nxt[b] = sink_r[b];
			tmr_nxt[b] = tmr_r[b];
			vs_cnt_nxt[b] = vs_cnt_r[b];
			fly_tmr_nxt[b] = fly_tmr_r[b];
			unique case (sink_r[b])
				SK_IDLE: begin
					// oscillator trigger turns the sink on, also as a retry
					if (active && !lock_r[b] && rs.osc_trig[b]) begin
						sink_nxt[b] = SK_BLANK; // RQ2
						tmr_nxt[b] = '0;
					end
				end
				SK_BLANK: begin
					// comparators ignored to ride over switching spikes
					tmr_nxt[b] = tmr_r[b] + TMR_W'(1); // RQ3
					if (tmr_r[b] >= TMR_W'(BLANK_CYC - 1)) begin
						sink_nxt[b] = SK_SHORTWIN; // RQ3
					end
				end
				SK_SHORTWIN: begin
					tmr_nxt[b] = tmr_r[b] + TMR_W'(1);
					if (lv.oc_short[b]) begin
						sink_nxt[b] = SK_IDLE; // RQ1 RQ4
						vs_det = 1'b1; // RQ1 RQ4
					end else if (tmr_r[b] >= TMR_W'(PWM_CYC - 1)) begin
						sink_nxt[b] = SK_PWM;
					end
				end
				SK_PWM: begin
					// nominal threshold is plain regulation, never an error
					if (lv.oc_nom[b]) begin
						sink_nxt[b] = SK_IDLE; // RQ5
						chop = 1'b1; // RQ5
					end
				end
			endcase
			if (!active) begin
				sink_nxt[b] = SK_IDLE;
			end
			// repeated shorts: retry on the next triggers, then lock out
			if (vs_det) begin
				vs_cnt_nxt[b] = vs_cnt_r[b] + 4'h1; // RQ2
				if (vs_cnt_r[b] + 4'h1 >= VS_LIMIT) begin
					lock_nxt[b] = 1'b1; // RQ24
					vs_cnt_nxt[b] = '0;
				end
			end else if (chop || apply) begin
				vs_cnt_nxt[b] = '0;
			end
			// overload coinciding with sink short reports as overload only
			if (vs_det && !ovl_det) begin
				vs_short_nxt = 1'b1; // RQ2 RQ8 RQ14
				vs_set = 1'b1;
			end else if (chop) begin
				vs_clr = 1'b1; // RQ14
			end
			if (ovl_det) begin
				ovl_nxt = 1'b1; // RQ6 RQ8
				ovl_off_nxt[b] = 1'b1; // RQ6
			end
			// filter advances on chops or on reversals, until it has settled
			if ((chop || (pol_chg && ready_r)) && !settled) begin
				filt_nxt = filt_r + 3'h1; // RQ13
			end
			if (chop || (pol_chg && active && !hold)) begin
				// hold reversals are not checked: the flyback is too short there
				fly_wait_nxt[b] = 1'b1; // RQ9 RQ10 RQ15 RQ16
				fly_tmr_nxt[b] = '0;
			end else if (fly_wait_r[b]) begin
				fly_tmr_nxt[b] = fly_tmr_r[b] + TMR_W'(1);
				if (lv.flyback[b]) begin
					fly_wait_nxt[b] = 1'b0;
					if (settled) begin
						open_nxt = 1'b0;
					end
				end else if (fly_tmr_r[b] >= TMR_W'(FLY_CYC - 1)) begin
					fly_wait_nxt[b] = 1'b0;
					open_nxt = 1'b1; // RQ9 RQ13
				end
			end
			// unsettled hold reversals may show a random open load
			if (pol_chg && ready_r && hold && !settled && !lv.flyback[b]) begin
				open_nxt = 1'b1;
			end
			gate_nxt[b].src1 = active && bc.polarity;
			gate_nxt[b].src2 = active && !bc.polarity;
			gate_nxt[b].sink1 = (sink_r[b] != SK_IDLE) && !bc.polarity;
			gate_nxt[b].sink2 = (sink_r[b] != SK_IDLE) && bc.polarity;
		end
		if (vs_clr && !vs_set) begin // a same-cycle short on either bridge wins
			vs_short_nxt = 1'b0; // RQ14
		end
		// settling in hold mode drops a spurious open-load report
		if (filt_nxt >= FILT_SETTLE && !settled) begin
			if (sbd_cfg_of(cfg_r, 0).current == HOLD_CURRENT_CODE ||
					sbd_cfg_of(cfg_r, 1).current == HOLD_CURRENT_CODE) begin
				open_nxt = 1'b0; // RQ11
			end
		end
	end

	// register the bridge group; disable clears it like a reset
	always_ff @(posedge clock_i) begin
		if (reset_i || !awake) begin
			for (int b = 0; b < 2; b++) begin
				sink_r[b] <= SK_IDLE;
				tmr_r[b] <= '0;
				fly_tmr_r[b] <= '0;
				vs_cnt_r[b] <= '0;
				gate_r[b] <= '0;
			end
			fly_wait_r <= 2'b00;
			pol_r <= 2'b00;
			ovl_off_r <= 2'b00;
			lock_r <= 2'b00;
			vs_short_r <= 1'b0; // RQ14
			ovl_r <= 1'b0;
			open_r <= 1'b0;
			filt_r <= '0;
		end else begin
			sink_r <= sink_nxt;
			tmr_r <= tmr_nxt;
			fly_tmr_r <= fly_tmr_nxt;
			vs_cnt_r <= vs_cnt_nxt;
			gate_r <= gate_nxt;
			fly_wait_r <= fly_wait_nxt;
			pol_r <= pol_nxt;
			ovl_off_r <= ovl_off_nxt;
			lock_r <= lock_nxt;
			vs_short_r <= vs_short_nxt;
			ovl_r <= ovl_nxt;
			open_r <= open_nxt;
			filt_r <= filt_nxt;
		end
	end

	// status encoding; over-temperature forces both low, overload masks open load
	assign flag_up = ~(lv.overtemp | vs_short_r | (open_r & ~ovl_r)); // RQ12
	assign flag_lo = ~(lv.overtemp | ovl_r); // RQ12
	assign diag_flag_upper_o = flag_up;
	assign diag_flag_lower_o = flag_lo;
	assign gate_a_o = gate_r[0];
	assign gate_b_o = gate_r[1];
endmodule : sbd_ctrl

// ---- rtl/sbd_pkg.sv ----
// shared constants, carrier types and decoders for the stepper bridge serial controller
// Behaviour
// RQ1 - fast sink overcurrent after turn-on means supply short
// RQ2 - after supply short, retry on next 7 triggers
// RQ3 - sink overcurrent fully blanked right after turn-on
// RQ4 - short window uses high threshold, sets flag
// RQ5 - later nominal threshold only chops, no flag
// RQ6 - source overload drives lower flag low
// RQ7 - chip-select rising edge clears overload flag
// RQ8 - shorted load codes depend on event coincidence
// RQ9 - missing flyback after reversal drives upper low
// RQ10 - no open-load test in hold current
// RQ11 - spurious hold open-load clears within eight reversals
// RQ12 - two flag bits encode status four ways
// RQ13 - filter settles after four chops or reversals
// RQ14 - supply-short flag persists until chop or disable
// RQ15 - flyback diagnosis masked at hold reversal
// RQ16 - flyback check stays active during hold chopping
// RQ17 - enable falling edge wakes, ready after delay
// RQ18 - frame starts on select fall, sample rising
// RQ19 - next output bit shifted on falling clock
// RQ20 - apply frame only on multiple-of-eight clocks
// RQ21 - serial output driven only while selected
// RQ22 - byte fields: currents, polarities, two flags
// RQ23 - both current bits high disable bridge
// RQ24 - eight supply shorts lock sink until transfer
// RQ25 - flags loaded into top bits at frame start
// RQ26 - long frame applies the last eight bits
package sbd_pkg;
	// clock and times
	localparam int CLK_PERIOD_PS = 4000; // 250 MHz system clock
	localparam int BLANK_NS = 2000; // turn-on blanking, least time
	localparam int SHORT_WIN_NS = 5000; // end of short window, longest time
	localparam int FLYBACK_NS = 2000; // wait for a flyback pulse
	localparam int WAKE_US = 30; // enable to first clock, least time
	localparam int BLANK_CYC = (BLANK_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int PWM_CYC = (SHORT_WIN_NS * 1000) / CLK_PERIOD_PS;
	localparam int FLY_CYC = (FLYBACK_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int WAKE_CYC_DEF = (WAKE_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int TMR_W = 11; // holds PWM_CYC and FLY_CYC
	localparam int WAKE_W = 16; // holds the wake count
	// diagnosis counts
	localparam logic [3:0] VS_LIMIT = 4'h8; // detections before lock-out
	localparam logic [2:0] FILT_SETTLE = 3'h4; // filter events to settle
	// frame layout
	localparam int FRAME_BITS = 8;
	localparam int FLAG_UP_BIT = 7;
	localparam int FLAG_LO_BIT = 6;
	localparam int CFG_W = 6; // bits 5:0 hold the bridge settings
	localparam logic [CFG_W-1:0] CFG_RESET = 6'h36; // both bridges off
	localparam logic [2:0] BIT_CNT_ZERO = 3'h0;
	// current codes, upper bit first
	localparam logic [1:0] CODE_OFF = 2'h3;
	localparam logic [1:0] HOLD_CURRENT_CODE = 2'h2;
	localparam logic [1:0] FULL_CURRENT_CODE = 2'h0;
	// one bridge setting
	typedef struct packed {
		logic [1:0] current;
		logic polarity;
	} sbd_bridge_cfg_t;
	// four gate drives of a bridge
	typedef struct packed {
		logic src1;
		logic src2;
		logic sink1;
		logic sink2;
	} sbd_gate_t;
	// pins coming from outside the clock domain
	typedef struct packed {
		logic cs_low;
		logic sclk;
		logic sdi;
		logic enable_low_input;
		logic overtemp;
		logic [1:0] osc_trig;
		logic [1:0] oc_short;
		logic [1:0] oc_nom;
		logic [1:0] src_ovl;
		logic [1:0] flyback;
	} sbd_pins_t;
	localparam int PINS_W = $bits(sbd_pins_t);
	localparam logic [PINS_W-1:0] PINS_IDLE = 15'h4800; // deselected, clock low, disabled
	// sink transistor phases after a trigger
	typedef enum logic [1:0] {SK_IDLE, SK_BLANK, SK_SHORTWIN, SK_PWM} sbd_sink_t;
	// bridge 0 is A in bits 5:3, bridge 1 is B in bits 2:0
	function automatic sbd_bridge_cfg_t sbd_cfg_of(input logic [CFG_W-1:0] c, input int b);
		sbd_cfg_of = (b == 0) ? c[5:3] : c[2:0]; // RQ22
	endfunction : sbd_cfg_of
endpackage : sbd_pkg

// ---- rtl/sbd_sync.sv ----
// three-stage pin synchroniser with agreement filter and edge pulses
module sbd_sync import sbd_pkg::*; #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic reset_i,
	// raw pins and filtered view
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] level_o,
	output logic [W-1:0] rise_o,
	output logic [W-1:0] fall_o
);
	logic [W-1:0] s1_r; // metastable stage, read only by s2
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	logic [W-1:0] lvl_r; // accepted level
	logic [W-1:0] lvl_nxt;
	// a change counts once stages two and three agree
	always_comb begin
		lvl_nxt = lvl_r;
		for (int i = 0; i < W; i++) begin
			if (s2_r[i] == s3_r[i]) begin
				lvl_nxt[i] = s3_r[i];
			end
		end
	end
	// register the stages
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			s1_r <= INIT;
			s2_r <= INIT;
			s3_r <= INIT;
			lvl_r <= INIT;
		end else begin
			s1_r <= async_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
			lvl_r <= lvl_nxt;
		end
	end
	assign level_o = lvl_r;
	assign rise_o = lvl_nxt & ~lvl_r;
	assign fall_o = ~lvl_nxt & lvl_r;
endmodule : sbd_sync

// ---- sim/sbd_ctrl_monitor.sv ----
// port checker for the stepper bridge serial controller, bound into sbd_ctrl
module sbd_monitor import sbd_pkg::*; #(
	parameter int WAKE_CYC = 20
) (
	// clock, reset and serial link
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic cs_low_i,
	input wire logic sclk_i,
	input wire logic sdo_o,
	input wire logic sdo_oe_o,
	// enable, events and status
	input wire logic enable_low_input_i,
	input wire logic ready_o,
	input wire logic [1:0] src_ovl_i,
	input wire logic overtemp_i,
	input wire logic diag_flag_upper_o,
	input wire logic diag_flag_lower_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [15:0] low_cnt_r; // cycles the enable has been low, saturating
	logic [15:0] low_cnt_nxt;
	// saturate so a long run never wraps back under the wake count
	always_comb begin
		low_cnt_nxt = low_cnt_r + {15'h0, low_cnt_r != 16'hFFFF};
		if (enable_low_input_i) low_cnt_nxt = 16'h0;
	end
	always_ff @(posedge clock_i) begin
		low_cnt_r <= reset_i ? 16'h0 : low_cnt_nxt;
	end
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (reset_i);
	// long enough to cover the pin synchroniser
	sequence cs_idle_s; cs_low_i [*8]; endsequence
	sequence cs_busy_s; (!cs_low_i && ready_o) [*8]; endsequence
	chk_oe_released: assert property (cs_idle_s |-> !sdo_oe_o)
		else $error("sdo driven while deselected");
	chk_oe_driven: assert property (cs_busy_s |-> sdo_oe_o)
		else $error("sdo not driven while selected");
	chk_ready_wake: assert property ($rose(ready_o) |-> low_cnt_r >= WAKE_CYC)
		else $error("ready before wake delay");
	chk_ready_off: assert property (enable_low_input_i [*8] |-> !ready_o)
		else $error("ready while disabled");
	chk_temp_code: assert property ((overtemp_i && ready_o) [*8] |->
		!diag_flag_upper_o && !diag_flag_lower_o)
		else $error("no alarm code while hot");
	chk_ovl_flag: assert property ($rose(src_ovl_i[0]) && ready_o |->
		##[1:8] !diag_flag_lower_o)
		else $error("overload not flagged");
	chk_frame_top: assert property ($rose(sdo_oe_o) && ready_o |->
		##2 (sdo_o == diag_flag_upper_o))
		else $error("frame does not open with upper flag");
	chk_sdo_steady: assert property ((sdo_oe_o && $stable(sclk_i)) [*8] |-> $stable(sdo_o))
		else $error("sdo moved without clock fall");
endmodule : sbd_monitor

bind sbd_ctrl sbd_monitor #(.WAKE_CYC(WAKE_CYC)) u_mon (.clock_i, .reset_i, .cs_low_i,
	.sclk_i, .sdo_o, .sdo_oe_o, .enable_low_input_i, .ready_o, .src_ovl_i, .overtemp_i,
	.diag_flag_upper_o, .diag_flag_lower_o);

// ---- sim/sbd_host.sv ----
// serial host model that clocks frames into the controller
module sbd_host (
	// serial pins toward the controller
	output logic cs_low_o,
	output logic sclk_o,
	output logic sdi_o,
	input wire logic sdo_i,
	input wire logic sdo_oe_i
);
	timeunit 1ns;
	timeprecision 100ps;
	// idle: deselected, clock parked low between frames
	initial begin
		cs_low_o = 1'b1;
		sclk_o = 1'b0;
		sdi_o = 1'b0;
	end
	// n bits msb first at 125 ns period; sdo taken at each rising clock
	task automatic xfer(input int n, input logic [15:0] tx, output logic [15:0] rx);
		rx = 16'h0;
		cs_low_o = 1'b0;
		#200;
		for (int i = n - 1; i >= 0; i--) begin
			sdi_o = tx[i];
			#62.5 sclk_o = 1'b1;
			rx = {rx[14:0], sdo_oe_i ? sdo_i : 1'bx};
			#62.5 sclk_o = 1'b0;
			sdi_o = ~tx[i]; // data no longer held, so show the inverse
		end
		#200 cs_low_o = 1'b1;
		#300;
	endtask : xfer
endmodule : sbd_host

// ---- sim/test_stepper_bridge_diag_serial_ctrl.sv ----
// self-checking bench for the stepper bridge serial controller
module test_stepper_bridge_diag_serial_ctrl import sbd_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int WAKE = 20; // short wake count keeps the run brief
	logic clock_i = 1'b0;
	logic reset_i = 1'b1;
	logic cs_low, sclk, sdi, sdo, sdo_oe, ready, upper, lower;
	logic enable_low = 1'b1; // starts disabled
	logic overtemp = 1'b0;
	// bridge b event inputs stay idle, index 0 is bridge a
	logic [1:0] trig = 2'h0, oc_short = 2'h0, oc_nom = 2'h0, ovl = 2'h0, fly = 2'h0;
	sbd_gate_t gate_a, gate_b;
	logic [15:0] rx;
	int n_mismatch = 0;
	int n_compared = 0;
	always #2 clock_i = ~clock_i;
	sbd_ctrl #(.WAKE_CYC(WAKE)) dut (.clock_i, .reset_i, .cs_low_i(cs_low), .sclk_i(sclk),
		.sdi_i(sdi), .sdo_o(sdo), .sdo_oe_o(sdo_oe), .enable_low_input_i(enable_low),
		.ready_o(ready), .osc_trig_i(trig), .oc_short_i(oc_short), .oc_nom_i(oc_nom),
		.src_ovl_i(ovl), .flyback_i(fly), .overtemp_i(overtemp), .gate_a_o(gate_a),
		.gate_b_o(gate_b), .diag_flag_upper_o(upper), .diag_flag_lower_o(lower));
	sbd_host host (.cs_low_o(cs_low), .sclk_o(sclk), .sdi_o(sdi), .sdo_i(sdo),
		.sdo_oe_i(sdo_oe));
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic cyc(input int n);
		repeat (n) @(negedge clock_i);
	endtask : cyc
	task automatic complete_run();
		$display("compares %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : complete_run
	// bounded wait for the wake delay to run out
	task automatic wait_ready();
		int i;
		for (i = 0; i < 200 && ready !== 1'b1; i++) cyc(1);
		if (i == 200) begin
			n_mismatch++;
			complete_run();
		end
	endtask : wait_ready
	// oscillator trigger on bridge a, a short pulse, then a chop with flyback
	task automatic fire(input int t_short, input int t_nom);
		trig[0] = 1'b1;
		cyc(10);
		trig[0] = 1'b0;
		cyc(t_short - 10);
		oc_short[0] = 1'b1;
		cyc(20);
		oc_short[0] = 1'b0;
		cyc(10);
		if (t_short < 500) check("blanked sink", gate_a, 4'h9);
		else check("short flags", {upper, lower}, 2'b01);
		if (t_nom > 0) begin
			cyc(t_nom - t_short - 30);
			oc_nom[0] = 1'b1;
			cyc(20);
			oc_nom[0] = 1'b0;
			fly[0] = 1'b1; // the winding answers the chop
			cyc(10);
			check("chopped gates", gate_a, 4'h8);
			cyc(590);
			fly[0] = 1'b0;
		end
	endtask : fire
	task automatic test_start();
		check("reset gates", {gate_a, gate_b}, 8'h00);
		host.xfer(8, 16'h000E, rx);
		check("reset byte", rx[7:0], 8'hF6);
		cyc(20);
		check("bridge b off", gate_b, 4'h0);
		fly[0] = 1'b1; // the winding answers the first reversal
		cyc(20);
		fly[0] = 1'b0;
		fire(100, 1300);
		check("chop flags", {upper, lower}, 2'b11);
		$display("done start");
	endtask : test_start
	task automatic test_frames();
		host.xfer(7, 16'h003F, rx);
		host.xfer(16, 16'h3F1E, rx);
		check("long frame", rx, 16'hCEFF);
		host.xfer(8, 16'h001E, rx);
		check("applied byte", rx[7:0], 8'hDE);
		$display("done frames");
	endtask : test_frames
	task automatic test_ground();
		ovl[0] = 1'b1;
		cyc(10);
		ovl[0] = 1'b0;
		cyc(10);
		check("overload flags", {upper, lower}, 2'b10);
		host.xfer(8, 16'h001E, rx);
		check("overload byte", rx[7:6], 2'b10);
		cyc(20);
		check("overload cleared", lower, 1'b1);
		$display("done ground");
	endtask : test_ground
	task automatic test_temp();
		overtemp = 1'b1;
		cyc(10);
		check("alarm flags", {upper, lower}, 2'b00);
		host.xfer(8, 16'h001E, rx);
		check("alarm byte", rx[7:6], 2'b00);
		overtemp = 1'b0;
		cyc(10);
		check("alarm gone", {upper, lower}, 2'b11);
		$display("done temp");
	endtask : test_temp
	task automatic test_supply();
		fire(800, 0);
		host.xfer(8, 16'h001E, rx);
		check("short byte", rx[7:6], 2'b01);
		check("short kept", upper, 1'b0);
		enable_low = 1'b1;
		cyc(10);
		check("disabled", {ready, gate_a}, 5'h00);
		enable_low = 1'b0;
		wait_ready();
		check("wake flags", {upper, lower}, 2'b11);
		host.xfer(8, 16'h001E, rx);
		check("wake byte", rx[7:0], 8'hF6);
		cyc(500); // reversal with no flyback runs past the wait
		check("open load flags", {upper, lower}, 2'b01);
		$display("done supply");
	endtask : test_supply
	initial begin
		cyc(2);
		reset_i = 1'b0;
		enable_low = 1'b0;
		wait_ready();
		test_start();
		test_frames();
		test_ground();
		test_temp();
		test_supply();
		complete_run();
	end
endmodule : test_stepper_bridge_diag_serial_ctrl
